// [pkg/mps_pkg.sv]
// Shared constants, types and decode helpers of the microprogram sequencer.
// Assumes a single 100 MHz system clock and a classic Wishbone register port.
package mps_pkg;

	// Clock period; the block itself has no timed waits
	localparam int CLK_PERIOD_NS = 10;

	// Widths of the microprogram address, its matrix parts, the control fields and the bus
	localparam int ADDR_W  = 9;
	localparam int ROW_W   = 5;
	localparam int COL_W   = 4;
	localparam int AC_W    = 7;
	localparam int LATCH_W = 4;
	localparam int PR_W    = 3;
	localparam int FC_W    = 4;
	localparam int WB_AW   = 4;
	localparam int WB_DW   = 32;

	// Register byte offsets
	localparam logic [3:0] OFS_STATUS = 4'h0;
	localparam logic [3:0] OFS_CTRL   = 4'h4;
	localparam logic [3:0] OFS_ADDR   = 4'h8;

	// Status and control word field positions
	localparam int ST_ADDR_LSB  = 0;
	localparam int ST_C_BIT     = 9;
	localparam int ST_Z_BIT     = 10;
	localparam int ST_F_BIT     = 11;
	localparam int ST_LATCH_LSB = 12;
	localparam int CTRL_HOLD_BIT = 0;

	// Reset values
	localparam logic [8:0] ADDR_RST  = 9'h000;
	localparam logic [3:0] LATCH_RST = 4'h0;
	localparam logic [31:0] RDATA_RST = 32'h0000_0000;

	// Flag input functions (low two control bits)
	localparam logic [1:0] FI_BOTH   = 2'h0;
	localparam logic [1:0] FI_Z_ONLY = 2'h1;
	localparam logic [1:0] FI_C_ONLY = 2'h2;
	localparam logic [1:0] FI_HOLD   = 2'h3;

	// Flag output functions (high two control bits)
	localparam logic [1:0] FO_ZERO = 2'h0;
	localparam logic [1:0] FO_C    = 2'h1;
	localparam logic [1:0] FO_Z    = 2'h2;
	localparam logic [1:0] FO_ONE  = 2'h3;

	// Address control functions
	typedef enum logic [3:0] {
		FN_COL, FN_ZERO_ROW, FN_ROW, FN_FLAG_F, FN_FLAG_C, FN_FLAG_Z,
		FN_LATCH_A, FN_LATCH_B, FN_GROUP_EN, FN_LATCH_C, FN_PRIMARY
	} mps_func_e;

	// Flag state travelling out of the flag unit
	typedef struct packed {
		logic c;
		logic z;
		logic f;
	} mps_flags_s;

	// Whole sequencer state
	typedef struct packed {
		logic [ADDR_W-1:0]  addr;
		logic [LATCH_W-1:0] latch;
		logic               hold;
		logic               addrOeN;
		logic               ack;
		logic [WB_DW-1:0]   rdata;
	} mps_seq_s;

	// Flag unit state
	typedef struct packed {
		mps_flags_s fl;
	} mps_flag_st_s;

	// Decode the seven address control lines into a function
	function automatic mps_func_e mps_decode(input logic [AC_W-1:0] ac);
		mps_func_e fn;
		fn = FN_COL;
		casez (ac)
			7'b00?_????: fn = FN_COL;
			7'b010_????: fn = FN_ZERO_ROW;
			7'b011_????: fn = FN_ROW;
			7'b100_????: fn = FN_FLAG_F;
			7'b101_0???: fn = FN_FLAG_C;
			7'b101_1???: fn = FN_FLAG_Z;
			7'b110_0???: fn = FN_LATCH_A;
			7'b110_1???: fn = FN_LATCH_B;
			7'b111_0???: fn = FN_GROUP_EN;
			7'b111_10??: fn = FN_LATCH_C;
			default:     fn = FN_PRIMARY;
		endcase
		return fn;
	endfunction : mps_decode

endpackage : mps_pkg

// [core/mps_flag_unit.sv]
// Carry flag pair, carry-capture latch and flag output multiplexer.
// Assumes flag input and controls come from logic on the same clock.
`timescale 1ns/1ps
`default_nettype none
module mps_flag_unit
	import mps_pkg::*;
(
	input  wire logic            sys_clk,    // System clock
	input  wire logic            rst_n,      // Async reset, active low
	input  wire logic            freeze,     // Hold all flag state
	input  wire logic [FC_W-1:0] flagCtrlIn, // Flag control lines
	input  wire logic            flagInN,    // Carry from array, active low
	input  wire logic            enable,     // Output enable, active high
	output mps_flags_s           flags,      // Current C, Z and F
	output logic                 flagOutN,   // Carry to array, active low
	output logic                 flagOutOeN  // Low while driving
);

	mps_flag_st_s st_r;
	mps_flag_st_s st_nxt;
	logic         fIn;
	logic         foVal;

	assign fIn = ~flagInN;

	// Flag updates from the demultiplexed flag input
	always_comb begin
		st_nxt = st_r;
		if (!freeze) begin
			st_nxt.fl.f = fIn;
			case (flagCtrlIn[1:0])
				FI_BOTH: begin
					st_nxt.fl.c = fIn;
					st_nxt.fl.z = fIn;
				end
				FI_Z_ONLY: st_nxt.fl.z = fIn;
				FI_C_ONLY: st_nxt.fl.c = fIn;
				default:   st_nxt.fl = st_nxt.fl;
			endcase
		end
	end

	// State register
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	// Flag output multiplexer
	always_comb begin
		case (flagCtrlIn[3:2])
			FO_ZERO: foVal = 1'b0;
			FO_C:    foVal = st_r.fl.c;
			FO_Z:    foVal = st_r.fl.z;
			default: foVal = 1'b1;
		endcase
	end

	assign flags      = st_r.fl;
	assign flagOutN   = ~foVal;
	assign flagOutOeN = ~enable;

	a_fl_capture: assert property (@(posedge sys_clk) disable iff (!rst_n)
		!freeze |=> flags.f == !$past(flagInN))
		else $error("F latch did not capture flag input");

	a_fl_hold: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(flagCtrlIn[1:0] == FI_HOLD) || freeze |=> $stable({flags.c, flags.z}))
		else $error("Flags changed under hold");

	a_fl_force: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(flagCtrlIn[3:2] == FO_ONE) |-> !flagOutN)
		else $error("Flag output not forced to one");

	a_fl_forcezero: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(flagCtrlIn[3:2] == FO_ZERO) |-> flagOutN)
		else $error("Flag output not forced to zero");

endmodule : mps_flag_unit
`default_nettype wire

// [core/mps_sequencer.sv]
// Microprogram sequencer: address register, next-address logic, program
// latch and register port. Assumes microinstruction fields, instruction
// busses and the carry line come from logic on sys_clk; Wishbone classic.
`timescale 1ns/1ps
`default_nettype none
module mps_sequencer
	import mps_pkg::*;
(
	input  wire logic               sys_clk,            // System clock
	input  wire logic               rst_n,              // Async reset, active low
	input  wire logic               wb_cyc_i,           // Bus cycle
	input  wire logic               wb_stb_i,           // Bus strobe
	input  wire logic               wb_we_i,            // Write enable
	input  wire logic [WB_AW-1:0]   wb_adr_i,           // Byte address
	input  wire logic [WB_DW-1:0]   wb_dat_i,           // Write data
	input  wire logic [3:0]         wb_sel_i,           // Byte lanes
	output logic [WB_DW-1:0]        wb_dat_o,           // Read data
	output logic                    wb_ack_o,           // Acknowledge
	input  wire logic [3:0]         primaryInstrBusN,   // Primary bus, active low
	input  wire logic [3:0]         secondaryInstrBusN, // Secondary bus, active low
	input  wire logic [AC_W-1:0]    addrCtrl,           // Address control lines
	input  wire logic [FC_W-1:0]    flagCtrlIn,         // Flag control lines
	input  wire logic               flagInN,            // Flag input, active low
	input  wire logic               enable,             // Output enable
	input  wire logic               loadAddr,           // Address load
	output logic [ADDR_W-1:0]       microAddr,          // Microprogram address
	output logic                    microAddrOeN,       // Low while driving
	output logic [PR_W-1:0]         progLatchOut,       // Program latch outputs
	output logic                    progLatchOeN,       // Low while driving
	output logic                    flagOutN,           // Flag output, active low
	output logic                    flagOutOeN,         // Low while driving
	output logic                    irqStrobeEnable     // Interrupt strobe enable
);

	mps_seq_s   st_r;
	mps_seq_s   st_nxt;
	mps_flags_s flags;
	mps_func_e  func;
	logic       wbReq;
	logic       wbWr;
	logic [WB_DW-1:0] rdVal;

	// Next address from the function, the current address and the tests
	function automatic logic [ADDR_W-1:0] mps_next_addr(
		input mps_func_e          fn,
		input logic [AC_W-1:0]    ac,
		input logic [ADDR_W-1:0]  cur,
		input mps_flags_s         fl,
		input logic [LATCH_W-1:0] lat,
		input logic [3:0]         pxN
	);
		logic [ROW_W-1:0] row;
		logic [COL_W-1:0] col;
		row = cur[ADDR_W-1:COL_W];
		col = cur[COL_W-1:0];
		case (fn)
			FN_COL: row = ac[4:0];
			FN_ZERO_ROW: begin
				row = '0;
				col = ac[3:0];
			end
			FN_ROW: col = ac[3:0];
			FN_GROUP_EN: row = {row[4:3], ac[2:0]};
			FN_FLAG_F: begin
				row = {row[4], ac[3:0]};
				col = {col[3], 2'b01, fl.f};
			end
			FN_FLAG_C: begin
				row = {row[4:3], ac[2:0]};
				col = {col[3], 2'b01, fl.c};
			end
			FN_FLAG_Z: begin
				row = {row[4:3], ac[2:0]};
				col = {col[3], 2'b01, fl.z};
			end
			FN_LATCH_A: begin
				row = {row[4:3], ac[2:0]};
				col = lat;
			end
			FN_LATCH_B: begin
				row = {row[4:3], ac[2:0]};
				col = {col[3:2], lat[3:2]};
			end
			FN_LATCH_C: begin
				row = {row[4:2], ac[1:0]};
				col = {col[3:2], lat[1:0]};
			end
			default: begin
				row = {row[4:2], ac[1:0]};
				col = ~pxN;
			end
		endcase
		return {row, col};
	endfunction : mps_next_addr

	assign func = mps_decode(addrCtrl);

	// Bus request of this cycle; the answer comes one edge later
	assign wbReq = wb_cyc_i & wb_stb_i & ~st_r.ack;
	assign wbWr  = wbReq & wb_we_i;

	// Read multiplexer; unmapped offsets read zero
	always_comb begin
		rdVal = '0;
		if (wb_adr_i == OFS_STATUS) begin
			rdVal[ST_ADDR_LSB +: ADDR_W]   = st_r.addr;
			rdVal[ST_C_BIT]                = flags.c;
			rdVal[ST_Z_BIT]                = flags.z;
			rdVal[ST_F_BIT]                = flags.f;
			rdVal[ST_LATCH_LSB +: LATCH_W] = st_r.latch;
		end else if (wb_adr_i == OFS_CTRL) begin
			rdVal[CTRL_HOLD_BIT] = st_r.hold;
		end else if (wb_adr_i == OFS_ADDR) begin
			rdVal[ST_ADDR_LSB +: ADDR_W] = st_r.addr;
		end else begin
			rdVal = '0;
		end
	end

	// Next state of sequencer and bus slave
	always_comb begin
		st_nxt       = st_r;
		st_nxt.ack   = wbReq;
		st_nxt.rdata = (wbReq && !wb_we_i) ? rdVal : RDATA_RST;
		st_nxt.addrOeN = ~enable;
		if (!st_r.hold) begin
			if (func == FN_PRIMARY) begin
				st_nxt.latch = ~secondaryInstrBusN;
			end
			if (loadAddr) begin
				st_nxt.addr = {1'b0, ~primaryInstrBusN, ~secondaryInstrBusN};
			end else begin
				st_nxt.addr = mps_next_addr(func, addrCtrl, st_r.addr, flags,
					st_r.latch, primaryInstrBusN);
			end
		end
		// Control register write
		if (wbWr && (wb_adr_i == OFS_CTRL) && wb_sel_i[0]) begin
			st_nxt.hold = wb_dat_i[CTRL_HOLD_BIT];
		end
		// Direct address write beats the sequencer
		if (wbWr && (wb_adr_i == OFS_ADDR)) begin
			if (wb_sel_i[0]) begin
				st_nxt.addr[7:0] = wb_dat_i[7:0];
			end
			if (wb_sel_i[1]) begin
				st_nxt.addr[8] = wb_dat_i[8];
			end
		end
	end

	// State register
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			st_r.addr    <= ADDR_RST;
			st_r.latch   <= LATCH_RST;
			st_r.hold    <= 1'b0;
			st_r.addrOeN <= 1'b1;
			st_r.ack     <= 1'b0;
			st_r.rdata   <= RDATA_RST;
		end else begin
			st_r <= st_nxt;
		end
	end

	// Flag logic
	mps_flag_unit u_flag (
		.sys_clk    (sys_clk),
		.rst_n      (rst_n),
		.freeze     (st_r.hold),
		.flagCtrlIn (flagCtrlIn),
		.flagInN    (flagInN),
		.enable     (enable),
		.flags      (flags),
		.flagOutN   (flagOutN),
		.flagOutOeN (flagOutOeN)
	);

	// Outputs
	// Address bus from the register
	assign microAddr    = st_r.addr;
	assign microAddrOeN = st_r.addrOeN;
	assign wb_ack_o     = st_r.ack;
	assign wb_dat_o     = st_r.rdata;
	assign progLatchOut = st_r.latch[PR_W-1:0];
	// Latch outputs enabled without a clock
	assign progLatchOeN = ~(enable && (func == FN_GROUP_EN));
	assign irqStrobeEnable = (func == FN_ZERO_ROW);

	// Jump result lands on the next edge
	a_seq_rowjump: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(func == FN_ROW) && !loadAddr && !st_r.hold && !wbWr
		|=> microAddr == {$past(microAddr[8:4]), $past(addrCtrl[3:0])})
		else $error("Row jump gave wrong address");

	// Zero-row jump clears the row part
	a_seq_zerorow: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(func == FN_ZERO_ROW) && !loadAddr && !st_r.hold && !wbWr
		|=> microAddr[8:4] == 5'h00 && microAddr[3:0] == $past(addrCtrl[3:0]))
		else $error("Zero-row jump gave wrong address");

	a_seq_primary: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(func == FN_PRIMARY) && !loadAddr && !st_r.hold && !wbWr
		|=> microAddr[3:0] == ~$past(primaryInstrBusN))
		else $error("Primary bus test gave wrong column");

	a_seq_capture: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(func == FN_PRIMARY) && !st_r.hold
		|=> st_r.latch == ~$past(secondaryInstrBusN))
		else $error("Program latch missed secondary bus");

	// Latch test takes the current latch contents; result lands on the next edge
	a_seq_latchtest: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(func == FN_LATCH_A) && !loadAddr && !st_r.hold && !wbWr
		|=> microAddr[3:0] == $past(st_r.latch))
		else $error("Latch test gave wrong column");

	a_seq_load: assert property (@(posedge sys_clk) disable iff (!rst_n)
		loadAddr && !st_r.hold && !wbWr
		|=> microAddr == {1'b0, ~$past(primaryInstrBusN), ~$past(secondaryInstrBusN)})
		else $error("Load did not take instruction busses");

	// Latch drive tied to group jump
	a_seq_prdrive: assert property (@(posedge sys_clk) disable iff (!rst_n)
		!progLatchOeN |-> enable && (addrCtrl[6:3] == 4'b1110))
		else $error("Latch outputs driven outside group jump");

	a_seq_strobe: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(addrCtrl[6:4] != 3'b010) |-> !irqStrobeEnable)
		else $error("Strobe enable raised outside zero-row jump");

	// Strobe follows zero-row jump even under load
	a_seq_strobeon: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(addrCtrl[6:4] == 3'b010) && loadAddr |-> irqStrobeEnable)
		else $error("Strobe enable missing on zero-row jump");

	a_seq_oe: assert property (@(posedge sys_clk) disable iff (!rst_n)
		!enable ##1 !enable |-> microAddrOeN)
		else $error("Address outputs driven while disabled");

	// Bus acknowledge is a single cycle
	a_seq_ack: assert property (@(posedge sys_clk) disable iff (!rst_n)
		wb_ack_o |=> !wb_ack_o)
		else $error("Acknowledge held two cycles");

endmodule : mps_sequencer
`default_nettype wire

// [test/mps_array_model.sv]
// Behavioural carry logic of the processor array on the flag pins.
// Assumes the sequencer's flag pins on sys_clk; genCarry comes from the bench.
`timescale 1ns/1ps
`default_nettype none
module mps_array_model
	import mps_pkg::*;
(
	input  wire logic sys_clk,    // System clock
	input  wire logic rst_n,      // Async reset, active low
	input  wire logic flagOutN,   // Carry into array, active low
	input  wire logic flagOutOeN, // Low while sequencer drives
	input  wire logic genCarry,   // Carry made inside the slice
	output logic      flagInN     // Carry out of array, active low
);
	logic floatBit_r; // Stands in for an undriven carry-in line

	// Carry out mixes slice carry and carry in; a released line reads a toggling level
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			flagInN    <= 1'h1;
			floatBit_r <= 1'h0;
		end else begin
			floatBit_r <= ~floatBit_r;
			flagInN    <= ~(genCarry ^ (flagOutOeN ? floatBit_r : ~flagOutN));
		end
	end
endmodule : mps_array_model
`default_nettype wire

// [test/testbench.sv]
// Self-checking bench: random sequencing and register traffic against a behavioural model.
// Assumes one 100 MHz clock and the array model on the flag pins.
`timescale 1ns/1ps
`default_nettype none
module testbench
	import mps_pkg::*;
;
	logic              sys_clk, rst_n, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, enable, loadAddr;
	logic              flagInN, carryGen, runRand, microAddrOeN, progLatchOeN, flagOutN, flagOutOeN;
	logic              irqStrobeEnable, take;
	logic [WB_AW-1:0]  wb_adr_i;
	logic [3:0]        wb_sel_i, primaryInstrBusN, secondaryInstrBusN, flagCtrlIn;
	logic [WB_DW-1:0]  wb_dat_i, wb_dat_o, mDat;
	logic [AC_W-1:0]   addrCtrl;
	logic [ADDR_W-1:0] microAddr;
	logic [PR_W-1:0]   progLatchOut;
	int                mAddr, mLat, mC, mZ, mF, mHold, mOe, mAck, r, c, f, g, n, rd;
	int                cycles, fail_count, comparisons;

	mps_sequencer i_mps_sequencer (.sys_clk(sys_clk), .rst_n(rst_n), .wb_cyc_i(wb_cyc_i),
		.wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i),
		.wb_sel_i(wb_sel_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
		.primaryInstrBusN(primaryInstrBusN), .secondaryInstrBusN(secondaryInstrBusN),
		.addrCtrl(addrCtrl), .flagCtrlIn(flagCtrlIn), .flagInN(flagInN), .enable(enable),
		.loadAddr(loadAddr), .microAddr(microAddr), .microAddrOeN(microAddrOeN),
		.progLatchOut(progLatchOut), .progLatchOeN(progLatchOeN), .flagOutN(flagOutN),
		.flagOutOeN(flagOutOeN), .irqStrobeEnable(irqStrobeEnable));
	mps_array_model u_array (.sys_clk(sys_clk), .rst_n(rst_n), .flagOutN(flagOutN),
		.flagOutOeN(flagOutOeN), .genCarry(carryGen), .flagInN(flagInN));

	// Function number 0..10 from the address control value
	function automatic int fn_of(input int a);
		return (a < 32) ? 0 : (a < 48) ? 1 : (a < 64) ? 2 : (a < 80) ? 3 :
			(a < 120) ? 4 + (a - 80) / 8 : (a < 124) ? 9 : 10;
	endfunction : fn_of

	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		comparisons++;
		if (got !== exp) begin
			fail_count++;
			$display("wrong value %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk

	task automatic give_verdict;
		$display("comparisons %0d fail_count %0d", comparisons, fail_count);
		if (fail_count == 0 && comparisons > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask : give_verdict

	// Classic single cycle, held until ack is sampled high
	task automatic wb_xfer(input logic we, input logic [3:0] adr, input logic [31:0] dat, input logic [3:0] sel);
		int k = 0;
		@(posedge sys_clk);
		wb_cyc_i <= 1'h1;
		wb_stb_i <= 1'h1;
		wb_we_i  <= we;
		wb_adr_i <= adr;
		wb_dat_i <= dat;
		wb_sel_i <= sel;
		do begin
			@(posedge sys_clk);
			k++;
		end while (wb_ack_o !== 1'h1 && k < 50);
		if (k >= 50) fail_count++;
		wb_cyc_i <= 1'h0;
		wb_stb_i <= 1'h0;
	endtask : wb_xfer

	// Reference model, updated from pre-edge inputs
	always @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			{mAddr, mLat, mC, mZ, mF, mHold, mAck} = '0;
			mOe = 1;
			mDat = '0;
		end else begin
			take = wb_cyc_i && wb_stb_i && !mAck;
			r = mAddr / 16;
			c = mAddr % 16;
			f = fn_of(addrCtrl);
			// row and column per jump function
			case (f)
				0: r = addrCtrl % 32;
				1: begin r = 0; c = addrCtrl % 16; end
				2: c = addrCtrl % 16;
				3: begin r = (r & 16) | (addrCtrl % 16); c = (c & 8) | 2 | mF; end
				4: begin r = (r & 24) | (addrCtrl % 8); c = (c & 8) | 2 | mC; end
				5: begin r = (r & 24) | (addrCtrl % 8); c = (c & 8) | 2 | mZ; end
				6: begin r = (r & 24) | (addrCtrl % 8); c = mLat; end
				7: begin r = (r & 24) | (addrCtrl % 8); c = (c & 12) | (mLat / 4); end
				8: r = (r & 24) | (addrCtrl % 8);
				9: begin r = (r & 28) | (addrCtrl % 4); c = (c & 12) | (mLat % 4); end
				default: begin r = (r & 28) | (addrCtrl % 4); c = 15 - primaryInstrBusN; end
			endcase
			n = loadAddr ? {4'h0, ~primaryInstrBusN, ~secondaryInstrBusN} : r * 16 + c;
			rd = (wb_adr_i == OFS_STATUS) ? mLat * 4096 + mF * 2048 + mZ * 1024 + mC * 512 + mAddr :
				(wb_adr_i == OFS_CTRL) ? mHold : (wb_adr_i == OFS_ADDR) ? mAddr : 0;
			mDat = (take && !wb_we_i) ? rd : 0;
			mAck = take;
			mOe = !enable;
			if (!mHold) begin
				// latch catches secondary bus on primary jump
				if (f == 10) mLat = 15 - secondaryInstrBusN;
				if (!flagCtrlIn[1]) mZ = !flagInN;
				if (!flagCtrlIn[0]) mC = !flagInN;
				mF = !flagInN;
				mAddr = n;
			end
			if (take && wb_we_i && wb_adr_i == OFS_ADDR && wb_sel_i[0]) mAddr = (mAddr & 256) | (wb_dat_i & 255);
			if (take && wb_we_i && wb_adr_i == OFS_ADDR && wb_sel_i[1]) mAddr = (mAddr & 255) | (wb_dat_i & 256);
			if (take && wb_we_i && wb_adr_i == OFS_CTRL && wb_sel_i[0]) mHold = wb_dat_i[0];
		end
	end

	// Compare every result mid-cycle, where outputs have settled
	always @(negedge sys_clk) begin
		if (rst_n) begin
			g = fn_of(addrCtrl);
			chk("microAddr", mAddr, microAddr);
			chk("microAddrOeN", mOe, microAddrOeN);
			chk("progLatchOut", mLat % 8, progLatchOut);
			chk("progLatchOeN", !(enable && g == 8), progLatchOeN);
			chk("irqStrobeEnable", g == 1, irqStrobeEnable);
			chk("flagOutN", !(flagCtrlIn[3:2] == 1 ? mC : flagCtrlIn[3:2] == 2 ? mZ : flagCtrlIn[3:2] == 3), flagOutN);
			chk("flagOutOeN", !enable, flagOutOeN);
			chk("wb_ack_o", mAck, wb_ack_o);
			chk("wb_dat_o", mDat, wb_dat_o);
		end
	end

	// Random microinstruction fields and busses every cycle
	always @(posedge sys_clk) begin
		if (runRand) begin
			{addrCtrl, flagCtrlIn, primaryInstrBusN, secondaryInstrBusN, enable, carryGen} <= 21'($urandom);
			loadAddr <= ($urandom % 8) == 0;
		end
	end

	// Hang guard
	always @(posedge sys_clk) begin
		cycles++;
		if (cycles == 4000) begin
			fail_count++;
			give_verdict();
		end
	end

	initial begin
		sys_clk = 1'h0;
		forever #5 sys_clk = ~sys_clk;
	end

	initial begin
		void'($urandom(32'hd749_edaa));
		{rst_n, wb_cyc_i, wb_stb_i, wb_we_i, enable, loadAddr, carryGen, runRand} = '0;
		{wb_adr_i, wb_sel_i, primaryInstrBusN, secondaryInstrBusN, flagCtrlIn, addrCtrl} = '0;
		wb_dat_i = '0;
		repeat (12) @(posedge sys_clk);
		rst_n <= 1'h1;
		runRand <= 1'h1;
		repeat (600) @(posedge sys_clk);
		wb_xfer(1'h0, OFS_STATUS, 32'h0000_0000, 4'hf);
		wb_xfer(1'h1, OFS_CTRL, 32'h0000_0001, 4'h1);
		wb_xfer(1'h0, OFS_CTRL, 32'h0000_0000, 4'hf);
		repeat (6) @(posedge sys_clk);
		wb_xfer(1'h1, OFS_ADDR, 32'h0000_01a5, 4'h3);
		wb_xfer(1'h0, OFS_ADDR, 32'h0000_0000, 4'hf);
		wb_xfer(1'h1, OFS_ADDR, 32'h0000_00ff, 4'h1);
		wb_xfer(1'h1, 4'hc, 32'hffff_ffff, 4'hf);
		wb_xfer(1'h0, 4'hc, 32'h0000_0000, 4'hf);
		wb_xfer(1'h1, OFS_CTRL, 32'h0000_0000, 4'h1);
		wb_xfer(1'h0, OFS_STATUS, 32'h0000_0000, 4'hf);
		repeat (400) @(posedge sys_clk);
		// Second reset in mid-run with random traffic still going
		rst_n <= 1'h0;
		repeat (3) @(posedge sys_clk);
		rst_n <= 1'h1;
		repeat (100) @(posedge sys_clk);
		give_verdict();
	end
endmodule : testbench
`default_nettype wire
